// ---- common/ebs_pkg.sv ----
// Purpose: Shared types and constants for the external bus strobe block
// Assumes: One 50 MHz clock, synchronous active-high reset
// Notes:   Timing counts are in sys_clk cycles
package ebs_pkg;

  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned SPACE_N     = 4;
  localparam int unsigned MA_W        = 5;
  localparam int unsigned HI_ADDR_W   = 8;
  localparam int unsigned HI_ADDR_LSB = 16;
  localparam int unsigned DRAM_ROW_LSB = 13;
  localparam int unsigned DRAM_COL_LSB = 8;
  localparam logic [7:0]  DIV_SLOW     = 8'h20;
  localparam logic [7:0]  DIV_FAST     = 8'h08;
  localparam logic [1:0]  CLKSEL_DIV8  = 2'h0;
  localparam logic [1:0]  CLKSEL_DIV32 = 2'h1;
  localparam logic [1:0]  CLKSEL_SUB   = 2'h2;
  localparam logic [1:0]  CLKSEL_OFF   = 2'h3;
  localparam logic [3:0]  SEL_NONE_N   = 4'hF;

  // ************************************************************
  // Request from the core side
  // ************************************************************
  typedef struct packed {
    logic              write;
    logic              dram;
    logic [1:0]        space;
    logic [ADDR_W-1:0] addr;
  } ebs_req_t;

  // ************************************************************
  // Strobe group driven to the pins
  // ************************************************************
  typedef struct packed {
    logic rd_n;
    logic low_byte_store_n;
    logic high_byte_store_n;
    logic addr_latch;
    logic row_latch_n;
  } ebs_strobe_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_ROW  = 6'b000100,
    ST_DATA = 6'b001000,
    ST_DONE = 6'b010000,
    ST_HOLD = 6'b100000
  } ebs_state_t;

endpackage : ebs_pkg

// ---- hw/ebs_clkout.sv ----
// Purpose: Clock output selector with main divide-by-8/32 or sub clock
// Assumes: Sub oscillator input is slow and sampled on sys_clk
// Notes:   Output is registered
`timescale 1ns/1ps
`default_nettype none
module ebs_clkout (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [1:0] clk_sel,
  input  wire logic       sub_osc_in,
  output var  logic       clock_out_pin
);
  import ebs_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic       sub_s1;
    logic       sub_s2;
    logic       out;
  } ebs_ck_t;

  ebs_ck_t st_q, st_d;
  logic [7:0] half;

  always_comb begin
    half = (clk_sel == CLKSEL_DIV32) ? (DIV_SLOW >> 1) : (DIV_FAST >> 1);
    st_d = st_q;
    st_d.sub_s1 = sub_osc_in;
    st_d.sub_s2 = st_q.sub_s1;
    st_d.cnt = st_q.cnt + 5'h01;
    if ({3'h0, st_q.cnt} >= half - 8'h01) begin
      st_d.cnt = 5'h00;
    end
    case (clk_sel)
      CLKSEL_DIV8, CLKSEL_DIV32: begin
        if ({3'h0, st_q.cnt} >= half - 8'h01) st_d.out = ~st_q.out;
      end
      CLKSEL_SUB: st_d.out = st_q.sub_s2;
      default:    st_d.out = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) st_q <= '0;
    else      st_q <= st_d;
  end

  assign clock_out_pin = st_q.out;

  // Divide-by-8 toggles every 4 cycles
  property div8_p;
    @(posedge sys_clk) disable iff (srst)
      (clk_sel == CLKSEL_DIV8 && $past(clk_sel) == CLKSEL_DIV8 && $rose(clock_out_pin)
       && $past(clk_sel, 2) == CLKSEL_DIV8)
      ##1 (clk_sel == CLKSEL_DIV8) [*3]
      |-> clock_out_pin && $past(clock_out_pin) && $past(clock_out_pin, 2)
      ##1 !clock_out_pin;
  endproperty
  clk_div8_a: assert property (div8_p) else $error("clock divide-by-8 wrong");

endmodule : ebs_clkout
`default_nettype wire

// ---- hw/ebs_bus.sv ----
// Purpose: External bus control strobes, selects, hold and wait handling
// Assumes: Core issues one request and waits for done
// Notes:   All pin outputs are registered
`timescale 1ns/1ps
`default_nettype none
module ebs_bus (
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  input  wire logic                          req_valid,
  input  wire ebs_pkg::ebs_req_t             req,
  output var  logic                          req_done,
  input  wire logic                          single_strobe_mode,
  input  wire logic [1:0]                    clk_sel,
  input  wire logic                          hold_req_n,
  input  wire logic                          wait_req_n,
  input  wire logic                          main_osc_in,
  input  wire logic                          sub_osc_in,
  output var  logic [ebs_pkg::HI_ADDR_W-1:0] hi_addr,
  output var  logic [ebs_pkg::SPACE_N-1:0]   space_select_n,
  output var  logic [ebs_pkg::MA_W-1:0]      dram_mux_addr,
  output var  logic                          rd_n,
  output var  logic                          low_byte_store_n,
  output var  logic                          high_byte_store_n,
  output var  logic                          addr_latch,
  output var  logic                          row_latch_n,
  output var  logic                          bus_released_ack_n,
  output var  logic                          clock_out_pin
);
  import ebs_pkg::*;

  typedef struct packed {
    ebs_state_t            fsm;
    ebs_req_t              cur;
    logic                  mode1;
    ebs_strobe_t           stb;
    logic [HI_ADDR_W-1:0]  hi;
    logic [SPACE_N-1:0]    sel_n;
    logic [MA_W-1:0]       ma;
    logic                  ack_n;
    logic                  done;
  } ebs_bus_st_t;

  ebs_bus_st_t st_q, st_d;

  // Decode of the space number into one active-low select
  function automatic logic [SPACE_N-1:0] space_dec(input logic [1:0] sp);
    space_dec = ~(4'h1 << sp);
  endfunction

  function automatic logic [HI_ADDR_W-1:0] hi_bits(input logic [ADDR_W-1:0] a);
    hi_bits = a[HI_ADDR_LSB +: HI_ADDR_W];
    hi_bits[HI_ADDR_W-1] = ~a[ADDR_W-1];
  endfunction

  // ************************************************************
  // Bus cycle sequencer
  // ************************************************************
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.stb.addr_latch = 1'b0;
    case (st_q.fsm)
      ST_IDLE: begin
        st_d.stb.rd_n = 1'b1;
        st_d.stb.low_byte_store_n = 1'b1;
        st_d.stb.high_byte_store_n = 1'b1;
        st_d.stb.row_latch_n = 1'b1;
        st_d.sel_n = SEL_NONE_N;
        if (!hold_req_n) begin
          st_d.fsm = ST_HOLD;
          st_d.ack_n = 1'b0;
        end else if (req_valid) begin
          st_d.cur = req;
          st_d.mode1 = single_strobe_mode;
          st_d.hi = hi_bits(req.addr);
          st_d.sel_n = space_dec(req.space);
          st_d.stb.addr_latch = 1'b1;
          st_d.ma = req.addr[DRAM_ROW_LSB +: MA_W];
          st_d.fsm = req.dram ? ST_ROW : ST_ADDR;
        end
      end
      ST_ROW: begin
        st_d.stb.row_latch_n = 1'b0;
        st_d.fsm = ST_ADDR;
      end
      ST_ADDR: begin
        if (st_q.cur.dram) st_d.ma = st_q.cur.addr[DRAM_COL_LSB +: MA_W];
        if (!st_q.cur.write) begin
          st_d.stb.rd_n = 1'b0;
        end else if (st_q.mode1) begin
          st_d.stb.low_byte_store_n = 1'b0;
          st_d.stb.high_byte_store_n = ~st_q.cur.addr[0];
        end else begin
          st_d.stb.low_byte_store_n = st_q.cur.addr[0];
          st_d.stb.high_byte_store_n = ~st_q.cur.addr[0];
        end
        if (st_q.mode1 && !st_q.cur.write) begin
          st_d.stb.high_byte_store_n = ~st_q.cur.addr[0];
        end
        st_d.fsm = ST_DATA;
      end
      ST_DATA: begin
        if (wait_req_n) st_d.fsm = ST_DONE;
      end
      ST_DONE: begin
        st_d.stb.rd_n = 1'b1;
        st_d.stb.low_byte_store_n = 1'b1;
        st_d.stb.high_byte_store_n = 1'b1;
        st_d.stb.row_latch_n = 1'b1;
        st_d.sel_n = SEL_NONE_N;
        st_d.done = 1'b1;
        st_d.fsm = ST_IDLE;
      end
      ST_HOLD: begin
        if (hold_req_n) begin
          st_d.ack_n = 1'b1;
          st_d.fsm = ST_IDLE;
        end
      end
      default: st_d.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '{fsm: ST_IDLE, cur: '0, mode1: 1'b0,
                stb: '{rd_n: 1'b1, low_byte_store_n: 1'b1, high_byte_store_n: 1'b1,
                       addr_latch: 1'b0, row_latch_n: 1'b1},
                hi: '0, sel_n: SEL_NONE_N, ma: '0, ack_n: 1'b1, done: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign hi_addr            = st_q.hi;
  assign space_select_n     = st_q.sel_n;
  assign dram_mux_addr      = st_q.ma;
  assign rd_n               = st_q.stb.rd_n;
  assign low_byte_store_n   = st_q.stb.low_byte_store_n;
  assign high_byte_store_n  = st_q.stb.high_byte_store_n;
  assign addr_latch         = st_q.stb.addr_latch;
  assign row_latch_n        = st_q.stb.row_latch_n;
  assign bus_released_ack_n = st_q.ack_n;
  assign req_done           = st_q.done;

  // Main oscillator is taken as sys_clk itself; pin kept for board wiring
  logic osc_unused;
  assign osc_unused = main_osc_in;

  ebs_clkout u_clkout (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .clk_sel       (clk_sel),
    .sub_osc_in    (sub_osc_in),
    .clock_out_pin (clock_out_pin)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  sequence start_s;
    st_q.fsm == ST_IDLE && hold_req_n && req_valid;
  endsequence

  // Row stands one cycle before the row strobe, column follows it
  sequence row_then_col_s;
    dram_mux_addr == st_q.cur.addr[DRAM_ROW_LSB +: MA_W] ##1 !row_latch_n
    ##1 dram_mux_addr == st_q.cur.addr[DRAM_COL_LSB +: MA_W];
  endsequence

  hi_addr_a: assert property (@(posedge sys_clk) disable iff (srst)
    start_s |=> hi_addr[7] == ~st_q.cur.addr[23] && hi_addr[6:0] == st_q.cur.addr[22:16])
    else $error("upper address wrong");
  one_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    $countones(~space_select_n) <= 1) else $error("two selects active");
  sel_dec_a: assert property (@(posedge sys_clk) disable iff (srst)
    start_s |=> space_select_n == space_dec(st_q.cur.space)) else $error("select wrong");
  ale_a: assert property (@(posedge sys_clk) disable iff (srst)
    start_s |=> addr_latch ##1 !addr_latch) else $error("latch strobe wrong");
  row_col_a: assert property (@(posedge sys_clk) disable iff (srst)
    start_s ##1 st_q.cur.dram |-> row_then_col_s)
    else $error("dram row/col wrong");
  rd_a: assert property (@(posedge sys_clk) disable iff (srst)
    st_q.fsm == ST_DATA && !st_q.cur.write |-> !rd_n) else $error("read strobe off");
  wr_sep_a: assert property (@(posedge sys_clk) disable iff (srst)
    st_q.fsm == ST_DATA && st_q.cur.write && !st_q.mode1
    |-> low_byte_store_n == st_q.cur.addr[0] && high_byte_store_n == !st_q.cur.addr[0])
    else $error("byte strobes wrong");
  wr_one_a: assert property (@(posedge sys_clk) disable iff (srst)
    st_q.fsm == ST_DATA && st_q.mode1
    |-> high_byte_store_n == !st_q.cur.addr[0]
        && (low_byte_store_n == !st_q.cur.write)) else $error("single strobe wrong");
  idle_hi_a: assert property (@(posedge sys_clk) disable iff (srst)
    st_q.fsm inside {ST_IDLE, ST_HOLD} |-> rd_n && low_byte_store_n && high_byte_store_n)
    else $error("strobe active while idle");
  hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    st_q.fsm == ST_IDLE && !hold_req_n |=> !bus_released_ack_n && st_q.fsm == ST_HOLD)
    else $error("hold not entered");
  wait_a: assert property (@(posedge sys_clk) disable iff (srst)
    st_q.fsm == ST_DATA && !wait_req_n |=> st_q.fsm == ST_DATA) else $error("wait ignored");

endmodule : ebs_bus
`default_nettype wire

// ---- verif/ebs_far_model.sv ----
// Purpose: Far-side memory model that stretches bus cycles with wait requests
// Assumes: Shares sys_clk with the bus block
// Notes:   Wait length per access comes from the bench; wait line idles high
`timescale 1ns/1ps
`default_nettype none
module ebs_far_model (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic [ebs_pkg::SPACE_N-1:0] space_select_n,
  input  wire logic                        rd_n,
  input  wire logic                        low_byte_store_n,
  input  wire logic                        high_byte_store_n,
  input  wire logic [3:0]                  wait_len,
  output var  logic                        wait_req_n
);
  import ebs_pkg::*;
  logic [3:0] cnt_q;
  logic       busy_q;
  wire  logic strobe_on = !rd_n || !low_byte_store_n || !high_byte_store_n;
  always_ff @(posedge sys_clk) begin
    if (srst || space_select_n == SEL_NONE_N) begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
    end else if (strobe_on && !busy_q) begin
      cnt_q  <= (wait_len == 4'h0) ? 4'h0 : wait_len - 4'h1;
      busy_q <= 1'b1;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // Combinational so the first strobe cycle is already stretched
  assign wait_req_n = !(strobe_on && (busy_q ? cnt_q != 4'h0 : wait_len != 4'h0));
endmodule : ebs_far_model
`default_nettype wire

// ---- verif/test_external_bus_strobe_interface.sv ----
// Purpose: Self-checking bench for the external bus strobe block
// Assumes: 50 MHz sys_clk, inputs driven by NBA at the rising edge
// Notes:   Outputs sampled 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_strobe_interface;
  import ebs_pkg::*;
  logic sys_clk, srst, req_valid, req_done, mode, hold_req_n, wait_req_n;
  logic sub_osc_in = 1'b0;
  logic rd_n, lbs_n, hbs_n, addr_latch, row_latch_n, ack_n, clock_out_pin;
  logic [1:0] clk_sel;
  logic [3:0] wait_len, sel_n;
  logic [3:0] sub_cnt = 4'h0;
  logic [7:0] hi_addr;
  logic [4:0] ma;
  ebs_req_t req;
  int fail_count = 0;
  int n_compared = 0;
  ebs_bus dut (.sys_clk(sys_clk), .srst(srst), .req_valid(req_valid), .req(req),
    .req_done(req_done), .single_strobe_mode(mode), .clk_sel(clk_sel),
    .hold_req_n(hold_req_n), .wait_req_n(wait_req_n), .main_osc_in(1'b0),
    .sub_osc_in(sub_osc_in), .hi_addr(hi_addr), .space_select_n(sel_n),
    .dram_mux_addr(ma), .rd_n(rd_n), .low_byte_store_n(lbs_n),
    .high_byte_store_n(hbs_n), .addr_latch(addr_latch), .row_latch_n(row_latch_n),
    .bus_released_ack_n(ack_n), .clock_out_pin(clock_out_pin));
  ebs_far_model far (.sys_clk(sys_clk), .srst(srst), .space_select_n(sel_n),
    .rd_n(rd_n), .low_byte_store_n(lbs_n), .high_byte_store_n(hbs_n),
    .wait_len(wait_len), .wait_req_n(wait_req_n));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Sub clock: 12 sys_clk cycles a period
  always @(posedge sys_clk) begin
    sub_cnt <= (sub_cnt == 4'h5) ? 4'h0 : sub_cnt + 4'h1;
    if (sub_cnt == 4'h5) sub_osc_in <= ~sub_osc_in;
  end
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic access(input logic wr, input logic dr, input logic [1:0] sp,
                        input logic [23:0] ad, input logic md, input logic [3:0] w);
    logic sr, sl, sh, sa, sw, multi;
    logic [3:0] sel;
    logic [7:0] ha;
    logic [4:0] row, col;
    int lat, base;
    {sr, sl, sh, sa, sw, multi} = 6'h00;
    sel = SEL_NONE_N;
    {ha, row, col} = 18'h0;
    base = dr ? 5 : 4;
    @(posedge sys_clk);
    mode <= md;
    wait_len <= w;
    req <= '{write: wr, dram: dr, space: sp, addr: ad};
    req_valid <= 1'b1;
    // First pass samples just after the take edge, so lat counts from it
    for (lat = 1; lat < 40; lat++) begin
      @(posedge sys_clk);
      req_valid <= 1'b0;
      #1;
      sr |= !rd_n;
      sl |= !lbs_n;
      sh |= !hbs_n;
      sw |= !row_latch_n;
      if (addr_latch) {sa, ha, row} = {1'b1, hi_addr, ma};
      if (!rd_n || !lbs_n || !hbs_n) col = ma;
      if (sel_n !== SEL_NONE_N) sel = sel_n;
      if ($countones(~sel_n) > 1) multi = 1'b1;
      if (req_done === 1'b1) break;
    end
    if (lat >= 40) begin
      fail_count++;
      results();
    end
    check(lat >= base + int'(w) && lat <= base + int'(w) + 1, 1);
    check(sr, !wr);
    check(sl, wr && (md || !ad[0]));
    check(sh, md ? ad[0] : (wr && ad[0]));
    check(sa, 1);
    check(sw, dr);
    check(sel, 4'(~(4'h1 << sp)));
    check(multi, 0);
    check(ha, {~ad[23], ad[22:16]});
    if (dr) check({row, col}, {ad[17:13], ad[12:8]});
    @(posedge sys_clk);
    #1;
    check({rd_n, lbs_n, hbs_n, sel_n}, 7'h7F);
  endtask : access
  task automatic test_strobes();
    int i;
    // Single-strobe half stands for the narrow-bus setup
    for (i = 0; i < 8; i++) access(i[1], 1'b0, i[1:0] + i[2], 24'h81A5F0 ^ i[0], i[2], 4'h0);
    $display("test_strobes done");
  endtask : test_strobes
  task automatic test_dram_wait();
    access(1'b0, 1'b1, 2'h3, 24'h3E6B41, 1'b0, 4'h0);
    access(1'b1, 1'b1, 2'h2, 24'hC1A4C2, 1'b0, 4'h2);
    access(1'b1, 1'b0, 2'h1, 24'h00FF01, 1'b1, 4'h3);
    access(1'b0, 1'b0, 2'h0, 24'hFF0002, 1'b0, 4'h1);
    $display("test_dram_wait done");
  endtask : test_dram_wait
  task automatic test_hold();
    int i;
    logic busy;
    busy = 1'b0;
    @(posedge sys_clk);
    hold_req_n <= 1'b0;
    req <= '{write: 1'b1, dram: 1'b0, space: 2'h2, addr: 24'h123456};
    @(posedge sys_clk);
    req_valid <= 1'b1;
    repeat (6) begin
      @(posedge sys_clk);
      #1;
      busy |= addr_latch || sel_n !== SEL_NONE_N || req_done;
      check(ack_n, 0);
    end
    check(busy, 0);
    @(posedge sys_clk);
    hold_req_n <= 1'b1;
    for (i = 0; i < 20 && addr_latch !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i >= 20) begin
      fail_count++;
      results();
    end
    check(ack_n, 1);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    for (i = 0; i < 20 && req_done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i >= 20) begin
      fail_count++;
      results();
    end
    check(req_done, 1);
    $display("test_hold done");
  endtask : test_hold
  task automatic rise(output int n);
    logic prev;
    n = 0;
    prev = clock_out_pin;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
      if (clock_out_pin === 1'b1 && prev === 1'b0) break;
      prev = clock_out_pin;
    end while (n < 100);
  endtask : rise
  task automatic test_clkout();
    int n, i;
    int exp [3] = '{8, 32, 12};
    for (i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      clk_sel <= i[1:0];
      repeat (3) rise(n);
      check(n, exp[i]);
    end
    @(posedge sys_clk);
    clk_sel <= CLKSEL_OFF;
    repeat (3) @(posedge sys_clk);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      #1;
      n += clock_out_pin;
    end
    check(n, 0);
    $display("test_clkout done");
  endtask : test_clkout
  initial begin
    {srst, req_valid, mode, hold_req_n} = 4'b1001;
    {clk_sel, wait_len} = 6'h0;
    req = '0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    test_strobes();
    test_dram_wait();
    test_hold();
    test_clkout();
    results();
  end
endmodule : test_external_bus_strobe_interface
`default_nettype wire
